// >>> gleq_lane.sv
// Sticky equalization preset and hint fields of one lane.
`timescale 1ns/10ps
`default_nettype none
module gleq_lane
  import gleq_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Port mode
  input  wire logic        init,
  input  wire logic        is_dsp,
  input  wire logic        cap_en,
  // Received equalization TS2
  input  wire logic        rx_vld,
  input  wire logic [3:0]  rx_preset,
  input  wire logic [2:0]  rx_hint,
  // Loads
  input  wire logic        usr_ld,
  input  wire logic [3:0]  usr_preset,
  input  wire logic        ee_ld,
  input  wire logic [15:0] ee_data,
  // Field image
  output logic      [15:0] fld
);

  logic [3:0] ph1_q, ph1_d;
  logic [2:0] rxh_q, rxh_d;
  logic [3:0] txp_q, txp_d;
  logic [2:0] txh_q, txh_d;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    ph1_d = ph1_q;
    rxh_d = rxh_q;
    txp_d = txp_q;
    txh_d = txh_q;
    if (init && !is_dsp) begin
      txp_d = GLEQ_US_PRE_RST;
      txh_d = GLEQ_US_HINT_RST;
    end else if (is_dsp) begin
      if (ee_ld) begin
        ph1_d = ee_data[GLEQ_PH1_LSB +: GLEQ_PRE_W];
        rxh_d = ee_data[GLEQ_RXH_LSB +: GLEQ_HINT_W];
        txp_d = ee_data[GLEQ_TXP_LSB +: GLEQ_PRE_W];
        txh_d = ee_data[GLEQ_TXH_LSB +: GLEQ_HINT_W];
      end
      if (usr_ld) begin
        ph1_d = usr_preset;
        txp_d = usr_preset;
      end
      // The received hint is only recorded, never fed to receivers.
      if (rx_vld) begin
        rxh_d = rx_hint;
      end
    end else if (cap_en && rx_vld) begin
      txp_d = rx_preset;
      txh_d = rx_hint;
    end
  end

  // Only the power-on reset clears these; link resets leave them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph1_q <= GLEQ_DS_PRE_RST;
      rxh_q <= GLEQ_DS_HINT_RST;
      txp_q <= GLEQ_DS_PRE_RST;
      txh_q <= GLEQ_DS_HINT_RST;
    end else begin
      ph1_q <= ph1_d;
      rxh_q <= rxh_d;
      txp_q <= txp_d;
      txh_q <= txh_d;
    end
  end

  assign fld = {1'b0, txh_q, txp_q, 1'b0, rxh_q, ph1_q};

endmodule
`default_nettype wire

// >>> gleq_partner.sv
// Link partner model that sends equalization TS2s and adopts presets.
`timescale 1ns/10ps
`default_nettype none
module gleq_partner (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic [1:0] send,
  input  wire logic [3:0] tx_p,
  input  wire logic [2:0] tx_h,
  input  wire logic       speed_chg,
  // TS2 contents sent by the port
  input  wire logic [7:0] ts2_preset,
  input  wire logic [5:0] ts2_hint,
  // TS2s received by the port
  output logic      [1:0] rx_vld,
  output logic      [7:0] rx_preset,
  output logic      [5:0] rx_hint,
  // Settings taken after the speed change
  output logic      [7:0] adopt_preset,
  output logic      [5:0] adopt_hint
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_vld       <= 2'h0;
      rx_preset    <= 8'h00;
      rx_hint      <= 6'h00;
      adopt_preset <= 8'h00;
      adopt_hint   <= 6'h00;
    end else begin
      rx_vld <= send;
      // Stale symbols toggle so a capture one cycle late cannot match by luck.
      rx_preset <= (|send) ? {2{tx_p}} : ~rx_preset;
      rx_hint   <= (|send) ? {2{tx_h}} : ~rx_hint;
      if (speed_chg) begin
        adopt_preset <= ts2_preset;
        adopt_hint   <= ts2_hint;
      end
    end
  end
endmodule
`default_nettype wire

// >>> gleq_pkg.sv
// Constants for the Gen 3 lane equalization preset register pair.
package gleq_pkg;

  // ----------------------------------------------------------------
  // Register offsets and half-word placement
  // ----------------------------------------------------------------
  localparam logic [11:0] GLEQ_OFS_A    = 12'h120;
  localparam logic [11:0] GLEQ_OFS_B    = 12'h124;
  localparam int          GLEQ_HALF_W   = 16;
  localparam int          GLEQ_LANES    = 2;

  // ----------------------------------------------------------------
  // Field positions inside one lane half-word
  // ----------------------------------------------------------------
  localparam int GLEQ_PH1_LSB = 0;
  localparam int GLEQ_RXH_LSB = 4;
  localparam int GLEQ_TXP_LSB = 8;
  localparam int GLEQ_TXH_LSB = 12;
  localparam int GLEQ_PRE_W   = 4;
  localparam int GLEQ_HINT_W  = 3;

  // Bits that exist on each port type; the rest read as zero.
  localparam logic [15:0] GLEQ_DSP_MASK = 16'h7F7F;
  localparam logic [15:0] GLEQ_USP_MASK = 16'h7F00;

  // Position of the cross-link bit inside the 3-bit margin field.
  localparam int GLEQ_XLINK_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] GLEQ_US_PRE_RST  = 4'hF;
  localparam logic [2:0] GLEQ_US_HINT_RST = 3'h7;
  localparam logic [3:0] GLEQ_DS_PRE_RST  = 4'h0;
  localparam logic [2:0] GLEQ_DS_HINT_RST = 3'h0;

endpackage

// >>> gleq_regs.sv
// Register pair for the lane 5 and lane 6 equalization presets.
`timescale 1ns/10ps
`default_nettype none
module gleq_regs
  import gleq_pkg::*;
#(
  parameter int LANES = GLEQ_LANES
)
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Port configuration
  input  wire logic                  is_dsp,
  input  wire logic [2:0]            tx_margin,
  // Configuration read port
  input  wire logic                  cfg_rd,
  input  wire logic [11:0]           cfg_addr,
  output logic                       cfg_ack,
  output logic      [31:0]           cfg_rdata,
  // User lane equalization control load
  input  wire logic [LANES-1:0]      usr_ld,
  input  wire logic [3:0]            usr_preset,
  // Serial EEPROM or I2C load
  input  wire logic [LANES-1:0]      ee_ld,
  input  wire logic [15:0]           ee_data,
  // Received equalization TS2s
  input  wire logic [LANES-1:0]      rx_vld,
  input  wire logic [LANES*4-1:0]    rx_preset,
  input  wire logic [LANES*3-1:0]    rx_hint,
  // Transmit side
  output logic      [LANES*4-1:0]    ph1_preset,
  output logic      [LANES*4-1:0]    ts2_preset,
  output logic      [LANES*3-1:0]    ts2_hint
);

  logic [LANES-1:0][15:0] fld;
  logic                   init_q, init_d;
  logic                   ack_q, ack_d;
  logic [31:0]            rdata_q, rdata_d;
  logic                   cap_en;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Masks a lane image to the bits that exist on this port type.
  function automatic logic [15:0] lane_view(input logic [15:0] f,
                                            input logic        dsp);
    lane_view = f & (dsp ? GLEQ_DSP_MASK : GLEQ_USP_MASK);
  endfunction

  // Capture is legal only on an upstream port with cross-link cleared.
  assign cap_en = !is_dsp && !tx_margin[GLEQ_XLINK_BIT];

  // ----------------------------------------------------------------
  // Lane fields
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    gleq_lane u_lane (
      .clock      (clock),
      .rst        (rst),
      .init       (init_q),
      .is_dsp     (is_dsp),
      .cap_en     (cap_en),
      .rx_vld     (rx_vld[g]),
      .rx_preset  (rx_preset[g*4 +: 4]),
      .rx_hint    (rx_hint[g*3 +: 3]),
      .usr_ld     (usr_ld[g]),
      .usr_preset (usr_preset),
      .ee_ld      (ee_ld[g]),
      .ee_data    (ee_data),
      .fld        (fld[g])
    );
    assign ph1_preset[g*4 +: 4] =
      fld[g][GLEQ_PH1_LSB +: GLEQ_PRE_W];
    assign ts2_preset[g*4 +: 4] =
      fld[g][GLEQ_TXP_LSB +: GLEQ_PRE_W];
    assign ts2_hint[g*3 +: 3] =
      fld[g][GLEQ_TXH_LSB +: GLEQ_HINT_W];
  end

  // ----------------------------------------------------------------
  // Init pulse and read port
  // ----------------------------------------------------------------
  // The async reset cannot load a port-type dependent value, so the
  // upstream defaults are written on the first edge after release.
  always_comb begin
    init_d  = 1'b0;
    ack_d   = cfg_rd;
    rdata_d = rdata_q;
    if (cfg_rd) begin
      unique case (cfg_addr)
        GLEQ_OFS_A: rdata_d = {lane_view(fld[0], is_dsp),
                               16'h0000};
        GLEQ_OFS_B: rdata_d = {16'h0000,
                               lane_view(fld[1], is_dsp)};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_q  <= 1'b1;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      init_q  <= init_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack   = ack_q;
  assign cfg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  for (genvar a = 0; a < LANES; a++) begin : g_chk
    usr_load_a: assert property (
      is_dsp && usr_ld[a] && !init_q ##1 is_dsp |->
      ph1_preset[a*4 +: 4] == $past(usr_preset) &&
      ts2_preset[a*4 +: 4] == $past(usr_preset))
      else $error("user preset load not applied");

    ds_hint_a: assert property (
      is_dsp && rx_vld[a] |=>
      fld[a][GLEQ_RXH_LSB +: 3] == $past(rx_hint[a*3 +: 3]))
      else $error("downstream hint not recorded");

    hint_iso_a: assert property (
      is_dsp && rx_vld[a] && !usr_ld[a] && !ee_ld[a] |=>
      $stable(ph1_preset[a*4 +: 4]) &&
      $stable(ts2_preset[a*4 +: 4]))
      else $error("received hint disturbed presets");

    us_cap_a: assert property (
      !is_dsp && !tx_margin[1] && rx_vld[a] && !init_q |=>
      fld[a][GLEQ_TXP_LSB +: 4] == $past(rx_preset[a*4 +: 4]) &&
      fld[a][GLEQ_TXH_LSB +: 3] == $past(rx_hint[a*3 +: 3]))
      else $error("upstream capture missed");

    xlink_hold_a: assert property (
      !is_dsp && tx_margin[1] && !init_q ##1 !is_dsp |->
      $stable(fld[a]))
      else $error("upstream field moved with cross-link on");

    ee_load_a: assert property (
      is_dsp && ee_ld[a] && !usr_ld[a] && !rx_vld[a] |=>
      ts2_preset[a*4 +: 4] == $past(ee_data[11:8]) &&
      ts2_hint[a*3 +: 3] == $past(ee_data[14:12]))
      else $error("eeprom load not on TS2 fields");

    us_init_a: assert property (
      init_q && !is_dsp |=>
      fld[a][GLEQ_TXP_LSB +: 4] == GLEQ_US_PRE_RST &&
      fld[a][GLEQ_TXH_LSB +: 3] == GLEQ_US_HINT_RST)
      else $error("upstream default not all ones");

    us_no_ee_a: assert property (
      !is_dsp && ee_ld[a] && !(cap_en && rx_vld[a]) &&
      !init_q ##1 !is_dsp |-> $stable(fld[a]))
      else $error("upstream field took eeprom load");

    ds_init_a: assert property (
      init_q && is_dsp |-> fld[a] == 16'h0000)
      else $error("downstream fields not zero after reset");

    ds_sticky_a: assert property (
      is_dsp && !usr_ld[a] && !ee_ld[a] && !rx_vld[a] |=>
      $stable(fld[a]))
      else $error("downstream field moved without a load");

    us_sticky_a: assert property (
      !is_dsp && !init_q && !(cap_en && rx_vld[a]) |=>
      $stable(fld[a]))
      else $error("upstream field moved without a capture");

    ds_txh_keep_a: assert property (
      is_dsp && rx_vld[a] && !ee_ld[a] |=>
      $stable(ts2_hint[a*3 +: 3]))
      else $error("sent hint overwritten by received hint");

    us_unused_a: assert property (
      !is_dsp |-> fld[a][GLEQ_PH1_LSB +: 4] == 4'h0 &&
      fld[a][GLEQ_RXH_LSB +: 3] == 3'h0)
      else $error("upstream reserved field nonzero");
  end

  map_a_a: assert property (
    cfg_rd && cfg_addr == GLEQ_OFS_A |=>
    cfg_ack && cfg_rdata[15:0] == 16'h0000 &&
    cfg_rdata[31:16] == lane_view($past(fld[0]), $past(is_dsp)))
    else $error("lane 5 read misplaced");

  map_b_a: assert property (
    cfg_rd && cfg_addr == GLEQ_OFS_B |=>
    cfg_ack && cfg_rdata[31:16] == 16'h0000 &&
    cfg_rdata[15:0] == lane_view($past(fld[1]), $past(is_dsp)))
    else $error("lane 6 read misplaced");

  rsvd_zero_a: assert property (
    cfg_rd && !is_dsp |=>
    (cfg_rdata & 32'h80FF_80FF) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  ds_rsvd_a: assert property (
    cfg_rd && is_dsp |=>
    (cfg_rdata & 32'h8080_8080) == 32'h0000_0000)
    else $error("downstream reserved bits read nonzero");

  ack_follow_a: assert property (
    cfg_rd |=> cfg_ack)
    else $error("read not acknowledged");

  unmapped_read_a: assert property (
    cfg_rd && cfg_addr != GLEQ_OFS_A && cfg_addr != GLEQ_OFS_B |=>
    cfg_rdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");

  rdata_hold_a: assert property (
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");

  ack_once_a: assert property (
    !cfg_rd |=> !cfg_ack)
    else $error("spurious read acknowledge");

  usr_load_c: cover property (is_dsp && usr_ld[1] ##5 cfg_ack);
  us_cap_c:   cover property (cap_en && rx_vld[1] && !init_q);
  ee_load_c:  cover property (is_dsp && ee_ld[0] ##4 cfg_rd);
  xlink_c:    cover property (!is_dsp && tx_margin[1] && rx_vld[0]);

endmodule
`default_nettype wire

// >>> test_gen3_lane_eq_preset_regs.sv
// Self-checking bench for the lane equalization preset registers.
`timescale 1ns/10ps
`default_nettype none
module test_gen3_lane_eq_preset_regs;
  import gleq_pkg::*;
  logic        clock = 1'b0;
  logic        rst, is_dsp, cfg_rd, cfg_ack, speed_chg;
  logic [2:0]  tx_margin, tx_h;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_rdata;
  logic [1:0]  usr_ld, ee_ld, rx_vld, send;
  logic [3:0]  usr_preset, tx_p;
  logic [15:0] ee_data;
  logic [7:0]  rx_preset, ph1_preset, ts2_preset, adopt_preset;
  logic [5:0]  rx_hint, ts2_hint, adopt_hint;
  int          bad_count = 0;
  int          n_compared = 0;

  always #50 clock = ~clock;

  gleq_regs #(.LANES(2)) gleq_regs_i (.clock, .rst, .is_dsp, .tx_margin,
    .cfg_rd, .cfg_addr, .cfg_ack, .cfg_rdata, .usr_ld, .usr_preset, .ee_ld,
    .ee_data, .rx_vld, .rx_preset, .rx_hint, .ph1_preset, .ts2_preset,
    .ts2_hint);
  gleq_partner gleq_partner_i (.clock, .rst, .send, .tx_p, .tx_h,
    .speed_chg, .ts2_preset, .ts2_hint, .rx_vld, .rx_preset, .rx_hint,
    .adopt_preset, .adopt_hint);

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask

  // The answer comes exactly one edge after the read is taken.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1);
    chk(cfg_rdata, exp);
  endtask

  task automatic pulse(input logic [1:0] u, input logic [1:0] e,
                       input logic [1:0] s);
    @(posedge clock);
    usr_ld <= u;
    ee_ld  <= e;
    send   <= s;
    @(posedge clock);
    usr_ld <= 2'h0;
    ee_ld  <= 2'h0;
    send   <= 2'h0;
    step(2);
  endtask

  task automatic do_reset(input logic dsp, input logic [2:0] m);
    @(posedge clock);
    rst       <= 1'b1;
    is_dsp    <= dsp;
    tx_margin <= m;
    step(6);
    rst <= 1'b0;
    step(2);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst        <= 1'b1;
    is_dsp     <= 1'b1;
    tx_margin  <= 3'h2;
    cfg_rd     <= 1'b0;
    cfg_addr   <= 12'h000;
    usr_ld     <= 2'h0;
    usr_preset <= 4'h0;
    ee_ld      <= 2'h0;
    ee_data    <= 16'hFFFF;
    send       <= 2'h0;
    tx_p       <= 4'h9;
    tx_h       <= 3'h3;
    speed_chg  <= 1'b0;
    do_reset(1'b1, 3'h2);
    rd(GLEQ_OFS_A, 32'h0000_0000);
    rd(GLEQ_OFS_B, 32'h0000_0000);
    rd(12'h128, 32'h0000_0000);
    pulse(2'h0, 2'h1, 2'h0);
    rd(GLEQ_OFS_A, 32'h7F7F_0000);
    chk({28'h0, ph1_preset[3:0]}, 32'hF);
    chk({29'h0, ts2_hint[2:0]}, 32'h7);
    @(posedge clock);
    usr_preset <= 4'h5;
    pulse(2'h2, 2'h0, 2'h0);
    rd(GLEQ_OFS_B, 32'h0000_0505);
    chk({24'h0, ph1_preset}, 32'h5F);
    chk({24'h0, ts2_preset}, 32'h5F);
    pulse(2'h0, 2'h0, 2'h3);
    rd(GLEQ_OFS_A, 32'h7F3F_0000);
    rd(GLEQ_OFS_B, 32'h0000_0535);
    chk({24'h0, ts2_preset}, 32'h5F);
    chk({26'h0, ts2_hint}, 32'h07);
    @(posedge clock);
    speed_chg <= 1'b1;
    @(posedge clock);
    speed_chg <= 1'b0;
    step(1);
    chk({24'h0, adopt_preset}, 32'h5F);
    chk({26'h0, adopt_hint}, 32'h07);
    do_reset(1'b0, 3'h2);
    rd(GLEQ_OFS_A, 32'h7F00_0000);
    rd(GLEQ_OFS_B, 32'h0000_7F00);
    @(posedge clock);
    ee_data <= 16'h0000;
    pulse(2'h3, 2'h3, 2'h3);
    rd(GLEQ_OFS_A, 32'h7F00_0000);
    rd(GLEQ_OFS_B, 32'h0000_7F00);
    @(posedge clock);
    tx_margin <= 3'h5;
    tx_p      <= 4'hA;
    tx_h      <= 3'h2;
    pulse(2'h3, 2'h3, 2'h3);
    rd(GLEQ_OFS_A, 32'h2A00_0000);
    rd(GLEQ_OFS_B, 32'h0000_2A00);
    tally_and_finish;
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    #1_000_000;
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
